// ---- hdl/lfp_top.sv ----
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
module lfp_top #(
	parameter int TICK_CLKS = lfp_pkg::CYCLE_CLKS
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      ce_i,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	input  wire logic                      wb_we_i,
	input  wire logic [lfp_pkg::AW-1:0]    wb_adr_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	output logic                           wb_ack_o,
	input  wire logic signed [lfp_pkg::ZW-1:0] pos_seq_r_i,
	input  wire logic signed [lfp_pkg::ZW-1:0] pos_seq_x_i,
	input  wire logic [lfp_pkg::VW-1:0]    pos_seq_v_i,
	output logic [lfp_pkg::NUM_EL-1:0]     trip_std_o,
	output logic [lfp_pkg::NUM_EL-1:0]     trip_vs_o,
	output logic                           irq_o
);

	localparam int NE   = lfp_pkg::NUM_EL;
	localparam int ZW   = lfp_pkg::ZW;
	localparam int W    = ZW + 3;
	localparam int TAN_PAD = 16;
	localparam int DW   = ZW + TAN_PAD;
	localparam int TICK_W  = $clog2(TICK_CLKS + 1);

	// Register storage
	logic [lfp_pkg::CTRL_W-1:0] ctrl_q;
	logic [ZW-1:0]              diam_q   [NE];
	logic [ZW-1:0]              offs_q   [NE];
	logic [lfp_pkg::TW-1:0]     dly_q    [NE];
	logic [lfp_pkg::TW-1:0]     vsdly_q  [NE];
	logic [lfp_pkg::VW-1:0]     vsup_q;
	logic [lfp_pkg::ANG_W-1:0]  dirang_q;
	logic [lfp_pkg::EV_W-1:0]   irq_stat_q;
	logic [lfp_pkg::EV_W-1:0]   irq_en_q;
	logic [lfp_pkg::EV_W-1:0]   irq_clr;
	logic [lfp_pkg::EV_W-1:0]   events;
	logic [lfp_pkg::EV_W-1:0]   ev_prev_q;
	logic [lfp_pkg::ST_W-1:0]   status;

	// Bus handshake
	logic                       ack_q;
	logic [31:0]                rdat_q;
	logic                       bus_req;
	logic                       wr_stb;

	// Measurement path
	logic [TICK_W-1:0]          tick_cnt_q;
	logic                       tick_q;
	logic                       uv_q;
	logic                       dir_block_q;
	logic signed [DW-1:0]       dir_sum;
	logic [NE-1:0]              pick_q;
	logic [NE-1:0]              in_circle;

	// Tangent of the directional angle, fraction bits TAN_W
	function automatic logic [lfp_pkg::TAN_W-1:0] tan_q(input logic [lfp_pkg::ANG_W-1:0] deg);
		case (deg)
			5'h00:   tan_q = 14'h0000;
			5'h01:   tan_q = 14'h011e;
			5'h02:   tan_q = 14'h023c;
			5'h03:   tan_q = 14'h035b;
			5'h04:   tan_q = 14'h047a;
			5'h05:   tan_q = 14'h0599;
			5'h06:   tan_q = 14'h06ba;
			5'h07:   tan_q = 14'h07dc;
			5'h08:   tan_q = 14'h08ff;
			5'h09:   tan_q = 14'h0a23;
			5'h0a:   tan_q = 14'h0b49;
			5'h0b:   tan_q = 14'h0c71;
			5'h0c:   tan_q = 14'h0d9b;
			5'h0d:   tan_q = 14'h0ec7;
			5'h0e:   tan_q = 14'h0ff5;
			5'h0f:   tan_q = 14'h1126;
			5'h10:   tan_q = 14'h125a;
			5'h11:   tan_q = 14'h1391;
			5'h12:   tan_q = 14'h14cb;
			5'h13:   tan_q = 14'h160a;
			default: tan_q = 14'h174b;
		endcase
	endfunction

	// Address of one element's per-element register
	function automatic logic el_hit(input logic [lfp_pkg::AW-1:0] adr, input int e,
		input logic [lfp_pkg::AW-1:0] sub);
		logic [lfp_pkg::AW-1:0] base;
		base   = lfp_pkg::REG_EL_BASE + lfp_pkg::AW'(e) * lfp_pkg::REG_EL_STRIDE;
		el_hit = (adr == base + sub);
	endfunction

	// Byte-lane merge for the 16-bit settings
	function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		lane16 = old;
		if (sel[0])
			lane16[7:0] = dat[7:0];
		if (sel[1])
			lane16[15:8] = dat[15:8];
	endfunction

	assign bus_req  = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr_stb   = bus_req && wb_we_i && ce_i;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else if (ce_i)
			ack_q <= bus_req;
	end

	// Control, shared voltage level and shared angle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q   <= lfp_pkg::CTRL_RST;
			vsup_q   <= lfp_pkg::VSUP_RST;
			dirang_q <= lfp_pkg::DIRANG_RST;
		end
		else if (wr_stb)
		begin
			if (wb_adr_i == lfp_pkg::REG_CTRL && wb_sel_i[0])
				ctrl_q <= wb_dat_i[lfp_pkg::CTRL_W-1:0];
			if (wb_adr_i == lfp_pkg::REG_VSUP)
				vsup_q <= lane16(vsup_q, wb_dat_i, wb_sel_i);
			// Out-of-range angles clamp so the table never overruns
			if (wb_adr_i == lfp_pkg::REG_DIRANG && wb_sel_i[0])
			begin
				if (wb_dat_i[7:0] > 8'(lfp_pkg::DIRANG_MAX))
					dirang_q <= lfp_pkg::DIRANG_MAX;
				else
					dirang_q <= wb_dat_i[lfp_pkg::ANG_W-1:0];
			end
		end
	end

	// Per-element settings, each element its own copy
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			for (int e = 0; e < NE; e++)
			begin
				diam_q[e]  <= lfp_pkg::DIAM_RST;
				offs_q[e]  <= lfp_pkg::OFFS_RST;
				dly_q[e]   <= lfp_pkg::DLY_RST;
				vsdly_q[e] <= lfp_pkg::VSDLY_RST;
			end
		end
		else if (wr_stb)
		begin
			for (int e = 0; e < NE; e++)
			begin
				if (el_hit(wb_adr_i, e, lfp_pkg::SUB_DIAM))
					diam_q[e] <= lane16(diam_q[e], wb_dat_i, wb_sel_i);
				if (el_hit(wb_adr_i, e, lfp_pkg::SUB_OFFS))
					offs_q[e] <= lane16(offs_q[e], wb_dat_i, wb_sel_i);
				if (el_hit(wb_adr_i, e, lfp_pkg::SUB_DLY))
					dly_q[e] <= lane16(dly_q[e], wb_dat_i, wb_sel_i);
				if (el_hit(wb_adr_i, e, lfp_pkg::SUB_VSDLY))
					vsdly_q[e] <= lane16(vsdly_q[e], wb_dat_i, wb_sel_i);
			end
		end
	end

	// Read mux, registered with the ack; unmapped reads give zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdat_q <= '0;
		else if (ce_i && bus_req)
		begin
			rdat_q <= '0;
			if (!wb_we_i)
			begin
				case (wb_adr_i)
					lfp_pkg::REG_CTRL:     rdat_q <= 32'(ctrl_q);
					lfp_pkg::REG_VSUP:     rdat_q <= 32'(vsup_q);
					lfp_pkg::REG_DIRANG:   rdat_q <= 32'(dirang_q);
					lfp_pkg::REG_STATUS:   rdat_q <= 32'(status);
					lfp_pkg::REG_IRQ_STAT: rdat_q <= 32'(irq_stat_q);
					lfp_pkg::REG_IRQ_EN:   rdat_q <= 32'(irq_en_q);
					default:
					begin
						for (int e = 0; e < NE; e++)
						begin
							if (el_hit(wb_adr_i, e, lfp_pkg::SUB_DIAM))
								rdat_q <= 32'(diam_q[e]);
							if (el_hit(wb_adr_i, e, lfp_pkg::SUB_OFFS))
								rdat_q <= 32'(offs_q[e]);
							if (el_hit(wb_adr_i, e, lfp_pkg::SUB_DLY))
								rdat_q <= 32'(dly_q[e]);
							if (el_hit(wb_adr_i, e, lfp_pkg::SUB_VSDLY))
								rdat_q <= 32'(vsdly_q[e]);
						end
					end
				endcase
			end
		end
	end

	// Power-system cycle tick; timers count cycles, not clocks
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end
		else if (ce_i)
		begin
			tick_q <= (tick_cnt_q == TICK_W'(TICK_CLKS - 1));
			if (tick_cnt_q == TICK_W'(TICK_CLKS - 1))
				tick_cnt_q <= '0;
			else
				tick_cnt_q <= tick_cnt_q + 1'b1;
		end
	end

	// Directional line through the origin, tilted down by the angle;
	// operation is allowed only below it: x + r*tan < 0
	assign dir_sum = {{(DW-ZW-lfp_pkg::TAN_W){pos_seq_x_i[ZW-1]}}, pos_seq_x_i,
		{lfp_pkg::TAN_W{1'b0}}}
		+ ({{(DW-ZW){pos_seq_r_i[ZW-1]}}, pos_seq_r_i}
		* {{(DW-lfp_pkg::TAN_W){1'b0}}, tan_q(dirang_q)});

	// Shared undervoltage and directional supervision
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			uv_q        <= 1'b0;
			dir_block_q <= 1'b0;
		end
		else if (ce_i)
		begin
			uv_q        <= (pos_seq_v_i < vsup_q);
			dir_block_q <= !dir_sum[DW-1];
		end
	end

	// Mho circle per element; top edge at the offset, spanning the
	// diameter downward. Squares of doubled terms avoid halving.
	generate
		for (genvar g = 0; g < NE; g++)
		begin : g_el
			logic signed [W-1:0]   a_s;
			logic signed [W-1:0]   b_s;
			logic signed [2*W-1:0] a_sq;
			logic signed [2*W-1:0] b_sq;
			logic [2*ZW-1:0]       d_sq;
			logic [2*W:0]          lhs;

			assign a_s  = {{2{pos_seq_r_i[ZW-1]}}, pos_seq_r_i, 1'b0};
			assign b_s  = {{2{pos_seq_x_i[ZW-1]}}, pos_seq_x_i, 1'b0}
				- {{2{offs_q[g][ZW-1]}}, offs_q[g], 1'b0}
				+ {3'b000, diam_q[g]};
			assign a_sq = a_s * a_s;
			assign b_sq = b_s * b_s;
			assign d_sq = diam_q[g] * diam_q[g];
			assign lhs  = {1'b0, a_sq} + {1'b0, b_sq};
			assign in_circle[g] = (lhs <= {{(2*W+1-2*ZW){1'b0}}, d_sq});

			// Pickup: enabled, inside, and not held off by the direction
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
					pick_q[g] <= 1'b0;
				else if (ce_i)
					pick_q[g] <= ctrl_q[lfp_pkg::CTRL_EN_POS + g] && in_circle[g]
						&& !(ctrl_q[lfp_pkg::CTRL_DIR_EN_POS + g] && dir_block_q);
			end

			lfp_timer_pair #(
				.TW (lfp_pkg::TW)
			) u_timers (
				.clk_i      (clk_i),
				.rst_i      (rst_i),
				.ce_i       (ce_i),
				.tick_i     (tick_q),
				.pickup_i   (pick_q[g]),
				.uv_i       (uv_q),
				.vs_en_i    (ctrl_q[lfp_pkg::CTRL_VS_EN_POS + g]),
				.dly_std_i  (dly_q[g]),
				.dly_vs_i   (vsdly_q[g]),
				.trip_std_o (trip_std_o[g]),
				.trip_vs_o  (trip_vs_o[g])
			);
		end
	endgenerate

	// Live status view
	always_comb
	begin
		status = '0;
		status[lfp_pkg::ST_PICK_POS +: NE] = pick_q;
		status[lfp_pkg::ST_TSTD_POS +: NE] = trip_std_o;
		status[lfp_pkg::ST_TVS_POS +: NE]  = trip_vs_o;
		status[lfp_pkg::ST_UV_POS]         = uv_q;
		status[lfp_pkg::ST_DIRBLK_POS]     = dir_block_q;
	end

	assign events = status[lfp_pkg::EV_W-1:0];

	// Clear strobes from the write-only register
	assign irq_clr = (wr_stb && wb_adr_i == lfp_pkg::REG_IRQ_CLR && wb_sel_i[0])
		? wb_dat_i[lfp_pkg::EV_W-1:0] : '0;

	// Rising edges of pickup and trips set sticky bits; a new edge
	// in the clearing cycle is kept
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ev_prev_q  <= '0;
			irq_stat_q <= '0;
		end
		else if (ce_i)
		begin
			ev_prev_q  <= events;
			irq_stat_q <= (irq_stat_q & ~irq_clr) | (events & ~ev_prev_q);
		end
	end

	// Interrupt enable register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_en_q <= '0;
		else if (wr_stb && wb_adr_i == lfp_pkg::REG_IRQ_EN && wb_sel_i[0])
			irq_en_q <= wb_dat_i[lfp_pkg::EV_W-1:0];
	end

	assign irq_o = |(irq_stat_q & irq_en_q);

endmodule

// ---- hdl/lfp_pkg.sv ----
package lfp_pkg;

	// Clock and power-system timing
	localparam int CLK_PERIOD_NS   = 100;
	localparam int SYS_FREQ_HZ     = 60;
	localparam int SYS_CYCLE_NS    = 1_000_000_000 / SYS_FREQ_HZ;
	localparam int CYCLE_CLKS      = SYS_CYCLE_NS / CLK_PERIOD_NS;

	// Datapath widths
	localparam int NUM_EL          = 2;
	localparam int ZW              = 16;   // impedance, 0.01 ohm secondary units
	localparam int VW              = 16;   // voltage, 0.01 V secondary units
	localparam int TW              = 16;   // delay counts in power-system cycles
	localparam int ANG_W           = 5;
	localparam int TAN_W           = 14;   // tangent fraction bits
	localparam int AW              = 8;

	// Register byte offsets
	localparam logic [AW-1:0] REG_CTRL      = 8'h00;
	localparam logic [AW-1:0] REG_EL_BASE   = 8'h04;
	localparam logic [AW-1:0] REG_EL_STRIDE = 8'h10;
	localparam logic [AW-1:0] SUB_DIAM      = 8'h00;
	localparam logic [AW-1:0] SUB_OFFS      = 8'h04;
	localparam logic [AW-1:0] SUB_DLY       = 8'h08;
	localparam logic [AW-1:0] SUB_VSDLY     = 8'h0c;
	localparam logic [AW-1:0] REG_VSUP      = 8'h24;
	localparam logic [AW-1:0] REG_DIRANG    = 8'h28;
	localparam logic [AW-1:0] REG_STATUS    = 8'h2c;
	localparam logic [AW-1:0] REG_IRQ_STAT  = 8'h30;
	localparam logic [AW-1:0] REG_IRQ_CLR   = 8'h34;
	localparam logic [AW-1:0] REG_IRQ_EN    = 8'h38;

	// Control field positions (per element e: bit + e)
	localparam int CTRL_EN_POS     = 0;
	localparam int CTRL_VS_EN_POS  = 2;
	localparam int CTRL_DIR_EN_POS = 4;
	localparam int CTRL_W          = 6;

	// Live status and event field positions (per element e: bit + e)
	localparam int ST_PICK_POS     = 0;
	localparam int ST_TSTD_POS     = 2;
	localparam int ST_TVS_POS      = 4;
	localparam int ST_UV_POS       = 6;
	localparam int ST_DIRBLK_POS   = 7;
	localparam int ST_W            = 8;
	localparam int EV_W            = 6;

	// Values after reset, and the angle clamp limit
	localparam logic [CTRL_W-1:0] CTRL_RST   = 6'h00;
	localparam logic [ZW-1:0]     DIAM_RST   = 16'h0000;
	localparam logic [ZW-1:0]     OFFS_RST   = 16'h0000;
	localparam logic [TW-1:0]     DLY_RST    = 16'h000f;
	localparam logic [TW-1:0]     VSDLY_RST  = 16'h003c;
	localparam logic [VW-1:0]     VSUP_RST   = 16'h0000;
	localparam logic [ANG_W-1:0]  DIRANG_RST = 5'h0d;
	localparam logic [ANG_W-1:0]  DIRANG_MAX = 5'h14;

endpackage

// ---- hdl/lfp_timer_pair.sv ----
// Standard and voltage-supervised delay timers of one mho element
module lfp_timer_pair #(
	parameter int TW = lfp_pkg::TW
) (
	input  wire logic          clk_i,
	input  wire logic          rst_i,
	input  wire logic          ce_i,
	input  wire logic          tick_i,
	input  wire logic          pickup_i,
	input  wire logic          uv_i,
	input  wire logic          vs_en_i,
	input  wire logic [TW-1:0] dly_std_i,
	input  wire logic [TW-1:0] dly_vs_i,
	output logic               trip_std_o,
	output logic               trip_vs_o
);

	logic [TW-1:0] std_cnt_q;
	logic [TW-1:0] vs_cnt_q;
	logic          vs_run;

	// Supervised timer runs only under low voltage
	assign vs_run = pickup_i && vs_en_i && uv_i;

	// Standard timer, cleared when pickup drops
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			std_cnt_q <= '0;
		else if (ce_i)
		begin
			if (!pickup_i)
				std_cnt_q <= '0;
			else if (tick_i && std_cnt_q != '1)
				std_cnt_q <= std_cnt_q + 1'b1;
		end
	end

	// Supervised timer, cleared as soon as its start condition fails
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			vs_cnt_q <= '0;
		else if (ce_i)
		begin
			if (!vs_run)
				vs_cnt_q <= '0;
			else if (tick_i && vs_cnt_q != '1)
				vs_cnt_q <= vs_cnt_q + 1'b1;
		end
	end

	// Trips held while the count stays at or past its setting
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			trip_std_o <= 1'b0;
			trip_vs_o  <= 1'b0;
		end
		else if (ce_i)
		begin
			trip_std_o <= pickup_i && (std_cnt_q >= dly_std_i);
			trip_vs_o  <= vs_run && (vs_cnt_q >= dly_vs_i);
		end
	end

endmodule

// ---- bench/lfp_meter_model.sv ----
// Instrument transformer stand-in: primary quantities in, secondary out
module lfp_meter_model #(
	parameter int CT_RATIO = 2,
	parameter int VT_RATIO = 4
) (
	input  wire logic               clk_i,
	input  wire logic signed [31:0] pri_r_i,
	input  wire logic signed [31:0] pri_x_i,
	input  wire logic signed [31:0] pri_v_i,
	output logic signed [15:0]      pos_seq_r_o,
	output logic signed [15:0]      pos_seq_x_o,
	output logic        [15:0]      pos_seq_v_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Scaled once per clock, so the relay sees a step one edge late
	always_ff @(posedge clk_i)
	begin
		pos_seq_r_o <= 16'(pri_r_i * CT_RATIO / VT_RATIO);
		pos_seq_x_o <= 16'(pri_x_i * CT_RATIO / VT_RATIO);
		pos_seq_v_o <= 16'(pri_v_i / VT_RATIO);
	end
endmodule

// ---- bench/lfp_top_checker.sv ----
module lfp_top_checker (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        ce_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic        wb_ack_o,
	input wire logic [15:0] pos_seq_v_i,
	input wire logic [1:0]  trip_std_o,
	input wire logic [1:0]  trip_vs_o,
	input wire logic        irq_o
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [5:0]  ctrl_m;
	logic [15:0] vsup_m;
	logic [5:0]  ien_m;

	// Mirror of the settings the checks depend on, caught off the bus
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_m <= lfp_pkg::CTRL_RST;
			vsup_m <= lfp_pkg::VSUP_RST;
			ien_m <= 6'h00;
		end
		else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i)
		begin
			if (wb_adr_i == lfp_pkg::REG_CTRL && wb_sel_i[0])
				ctrl_m <= wb_dat_i[5:0];
			if (wb_adr_i == lfp_pkg::REG_VSUP && wb_sel_i[1:0] == 2'h3)
				vsup_m <= wb_dat_i[15:0];
			if (wb_adr_i == lfp_pkg::REG_IRQ_EN && wb_sel_i[0])
				ien_m <= wb_dat_i[5:0];
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Pipeline is three edges deep, so four quiet samples settle it
	sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i; endsequence
	sequence s_el0_off; !ctrl_m[0] [*4]; endsequence
	sequence s_vs1_off; !ctrl_m[3] [*4]; endsequence
	sequence s_v_high; (pos_seq_v_i >= vsup_m) [*4]; endsequence

	a_ack_follows: assert property (s_take |=> wb_ack_o)
		else $error("ack missing after request");
	a_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) && ce_i |=> !wb_ack_o)
		else $error("ack without request");
	a_reset_quiet: assert property (disable iff (1'b0) $fell(rst_i) |->
		trip_std_o == 2'h0 && trip_vs_o == 2'h0 && !irq_o && !wb_ack_o)
		else $error("outputs active out of reset");
	a_elem_off_quiet: assert property (s_el0_off |-> !trip_std_o[0] && !trip_vs_o[0])
		else $error("disabled element trips");
	a_vs_off_quiet: assert property (s_vs1_off |-> !trip_vs_o[1])
		else $error("supervised trip while disabled");
	a_uv_gate: assert property (s_v_high |-> trip_vs_o == 2'h0)
		else $error("supervised trip without undervoltage");
	a_irq_masked: assert property (ien_m == 6'h00 |-> !irq_o)
		else $error("interrupt while all masked");
endmodule

bind lfp_top lfp_top_checker lfp_top_checker_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .pos_seq_v_i(pos_seq_v_i),
	.trip_std_o(trip_std_o), .trip_vs_o(trip_vs_o), .irq_o(irq_o));

// ---- bench/loss_of_field_protection_tb.sv ----
module loss_of_field_protection_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        ce_i = 1'b1;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [15:0] r_s;
	logic [15:0] x_s;
	logic [15:0] v_s;
	logic [1:0]  trip_std_o;
	logic [1:0]  trip_vs_o;
	logic        irq_o;
	int          pr = 0;
	int          px = 0;
	int          pv = 0;
	int          n_fail = 0;
	int          total_checks = 0;
	logic [31:0] q;
	logic [7:0]  ra [6] = '{8'h00, 8'h0c, 8'h20, 8'h28, 8'h24, 8'h3c};
	logic [31:0] re [6] = '{32'h0, 32'h0f, 32'h3c, 32'h0d, 32'h0, 32'h0};

	always #50 clk_i = ~clk_i;

	// Short power-system tick keeps delay counts to a few dozen clocks
	lfp_top #(.TICK_CLKS(4)) lfp_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.pos_seq_r_i(r_s), .pos_seq_x_i(x_s), .pos_seq_v_i(v_s),
		.trip_std_o(trip_std_o), .trip_vs_o(trip_vs_o), .irq_o(irq_o));
	lfp_meter_model lfp_meter_model_i (.clk_i(clk_i), .pri_r_i(pr), .pri_x_i(px),
		.pri_v_i(pv), .pos_seq_r_o(r_s), .pos_seq_x_o(x_s), .pos_seq_v_o(v_s));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One classic cycle; byte lanes follow the width of the setting
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= (a == 8'h00 || a >= 8'h28) ? 4'h1 : 4'h3;
		// Ack and read data are taken at the same rising edge
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (wb_ack_o !== 1'b1);
		chk("ack wait", 32'(n), 32'h2);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic el(input int e, input int d, input int o, input int sd, input int vd);
		logic [7:0] b;
		b = lfp_pkg::REG_EL_BASE + lfp_pkg::REG_EL_STRIDE * 8'(e);
		wb(1'b1, b + lfp_pkg::SUB_DIAM, 32'(d));
		wb(1'b1, b + lfp_pkg::SUB_OFFS, 32'(o));
		wb(1'b1, b + lfp_pkg::SUB_DLY, 32'(sd));
		wb(1'b1, b + lfp_pkg::SUB_VSDLY, 32'(vd));
	endtask

	// Primary point; six clocks cover model, pickup and direction stages
	task automatic pt(input int r, input int x, input int v);
		@(posedge clk_i);
		pr <= r;
		px <= x;
		pv <= v;
		repeat (6) @(posedge clk_i);
	endtask

	function automatic logic in_mho(input int r, input int x, input int o, input int d);
		int c;
		c = o - d / 2;
		return r * r + (x - c) * (x - c) <= (d / 2) * (d / 2);
	endfunction

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Watchdog well past the roughly five hundred clocks the tests need
	initial
	begin
		repeat (8000) @(posedge clk_i);
		n_fail++;
		close_out();
	end

	// Main sequence
	initial
	begin
		int r;
		int x;
		void'($urandom(34907));
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (ra[i])
		begin
			wb(1'b0, ra[i], 32'h0);
			chk("reset value", q, re[i]);
		end
		$display("test 1 done");
		wb(1'b1, lfp_pkg::REG_DIRANG, 32'h1f);
		wb(1'b0, lfp_pkg::REG_DIRANG, 32'h0);
		chk("angle clamp", q, 32'h14);
		wb(1'b1, lfp_pkg::REG_DIRANG, 32'h0);
		wb(1'b0, lfp_pkg::REG_DIRANG, 32'h0);
		chk("angle zero", q, 32'h0);
		$display("test 2 done");
		el(0, 400, 0, 3, 60);
		el(1, 100, 0, 200, 60);
		wb(1'b1, lfp_pkg::REG_IRQ_EN, 32'h4);
		wb(1'b1, lfp_pkg::REG_CTRL, 32'h3);
		pt(0, -400, 40000);
		chk("trip early", 32'(trip_std_o), 32'h0);
		repeat (14) @(posedge clk_i);
		chk("trip std", 32'(trip_std_o), 32'h1);
		chk("trip vs", 32'(trip_vs_o), 32'h0);
		chk("irq", 32'(irq_o), 32'h1);
		wb(1'b0, lfp_pkg::REG_STATUS, 32'h0);
		chk("status", q, 32'h05);
		// Element 1 picked up on its boundary at the origin before the move
		wb(1'b0, lfp_pkg::REG_IRQ_STAT, 32'h0);
		chk("irq status", q, 32'h07);
		wb(1'b1, lfp_pkg::REG_IRQ_CLR, 32'h4);
		wb(1'b0, lfp_pkg::REG_IRQ_STAT, 32'h0);
		chk("irq cleared", q, 32'h03);
		chk("irq low", 32'(irq_o), 32'h0);
		pt(1000, 1000, 40000);
		chk("dropout", 32'(trip_std_o), 32'h0);
		$display("test 3 done");
		el(1, 400, 0, 255, 2);
		wb(1'b1, lfp_pkg::REG_VSUP, 32'h1000);
		wb(1'b1, lfp_pkg::REG_CTRL, 32'h0b);
		pt(0, -400, 4 * 32'h0800);
		repeat (14) @(posedge clk_i);
		chk("vs trip", 32'(trip_vs_o), 32'h2);
		chk("std beside vs", 32'(trip_std_o), 32'h1);
		pt(0, -400, 4 * 32'h1000);
		chk("vs at level", 32'(trip_vs_o), 32'h0);
		$display("test 4 done");
		el(0, 400, 200, 3, 60);
		el(1, 400, 200, 3, 60);
		wb(1'b1, lfp_pkg::REG_CTRL, 32'h33);
		pt(0, 100, 40000);
		wb(1'b0, lfp_pkg::REG_STATUS, 32'h0);
		chk("dir block", q & 32'h83, 32'h80);
		pt(0, -100, 40000);
		wb(1'b0, lfp_pkg::REG_STATUS, 32'h0);
		chk("dir pass", q & 32'h83, 32'h03);
		wb(1'b1, lfp_pkg::REG_DIRANG, 32'h14);
		pt(200, -60, 40000);
		wb(1'b0, lfp_pkg::REG_STATUS, 32'h0);
		chk("dir angle", q & 32'h83, 32'h80);
		$display("test 5 done");
		wb(1'b1, lfp_pkg::REG_DIRANG, 32'h0);
		wb(1'b1, lfp_pkg::REG_CTRL, 32'h3);
		el(0, 1000, 0, 3, 60);
		el(1, 400, 100, 3, 60);
		for (int i = 0; i < 24; i++)
		begin
			r = (i == 0) ? 0 : 2 * int'($urandom_range(600)) - 600;
			x = (i == 0) ? 0 : 2 * int'($urandom_range(600)) - 600;
			pt(r, x, 40000);
			wb(1'b0, lfp_pkg::REG_STATUS, 32'h0);
			chk("pickup", q & 32'h3, {30'h0, in_mho(r / 2, x / 2, 100, 400),
				in_mho(r / 2, x / 2, 0, 1000)});
		end
		$display("test 6 done");
		pt(0, -400, 40000);
		repeat (14) @(posedge clk_i);
		chk("trip both", 32'(trip_std_o), 32'h3);
		// Enable low while the point leaves both circles: trips must hold
		ce_i <= 1'b0;
		pt(1000, 1000, 40000);
		chk("frozen trips", 32'(trip_std_o), 32'h3);
		ce_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk("thawed dropout", 32'(trip_std_o), 32'h0);
		$display("test 7 done");
		close_out();
	end
endmodule
